// ===== verilog/cct_pkg.sv
// Purpose: Shared constants and types for the capture/compare timer.
// Assumes: One clock domain; count sources arrive as one-cycle tick enables.
// Notes: The named encodings of the count-source select field (SRC_OSC40, SRC_FASTFREE) live here.
`default_nettype none
package cct_pkg;
  localparam int CNT_W = 16;
  localparam int NCH = 4;
  localparam int SRC_W = 3;
  localparam int NSRC = 8;
  localparam int FILT_TAPS = 3;
  localparam int CH_A = 0;
  localparam logic [SRC_W-1:0] SRC_OSC40 = 3'h6;
  localparam logic [SRC_W-1:0] SRC_FASTFREE = 3'h7;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [3:0] FLAG_RST = 4'h0;
  typedef enum {CNT_IDLE, CNT_RUN, CNT_HALT} cct_cnt_state_t;
endpackage
`default_nettype wire

// ===== verilog/cct_timer.sv
// Purpose: 16-bit up counter with four capture/compare channels.
// Assumes: All inputs synchronous to core_clk_i; ce_i low freezes all state.
// Notes: Counter and flag writes land one cycle late, as software expects.
`timescale 1ns/1ps
`default_nettype none
module cct_timer #(
  parameter int NUM_CH = cct_pkg::NCH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic count_start_bit_i,
  input wire logic compare_clear_enable_i,
  input wire logic [cct_pkg::SRC_W-1:0] count_source_select_i,
  input wire logic [cct_pkg::NSRC-1:0] src_tick_i,
  input wire logic two_phase_pwm_mode_i,
  input wire logic compare_stop_select_i,
  input wire logic cnt_wr_i,
  input wire logic [cct_pkg::CNT_W-1:0] cnt_wdata_i,
  input wire logic flag_wr_i,
  input wire logic [cct_pkg::NCH-1:0] flag_wdata_i,
  input wire logic [cct_pkg::NCH-1:0] gr_wr_i,
  input wire logic [cct_pkg::CNT_W-1:0] gr_wdata_i,
  input wire logic [cct_pkg::NCH-1:0] capture_mode_i,
  input wire logic [cct_pkg::NCH-1:0] edge_select_low_i,
  input wire logic [cct_pkg::NCH-1:0] edge_select_high_i,
  input wire logic [cct_pkg::NCH-1:0] filter_enable_i,
  input wire logic filter_tick_i,
  input wire logic [cct_pkg::NCH-1:0] channel_io_pin_i,
  output logic [cct_pkg::CNT_W-1:0] counter_value_o,
  output logic [cct_pkg::NCH-1:0] timer_flag_status_o,
  output logic [cct_pkg::NCH-1:0][cct_pkg::CNT_W-1:0] channel_general_reg_o,
  output logic count_running_o
);
  import cct_pkg::*;

  if (NUM_CH != NCH) begin : g_bad_ch
    $error("NUM_CH must equal the channel count of the register layout.");
  end

  cct_cnt_state_t st, next_st;
  logic [CNT_W-1:0] counter, next_counter;
  logic [NCH-1:0] flags, next_flags;
  logic [NCH-1:0][CNT_W-1:0] gr, next_gr;
  logic cnt_wr_q, next_cnt_wr_q;
  logic [CNT_W-1:0] cnt_wdata_q, next_cnt_wdata_q;
  logic flag_wr_q, next_flag_wr_q;
  logic [NCH-1:0] flag_wdata_q, next_flag_wdata_q;
  logic [NCH-1:0] edge_hit;
  logic tick, match_a, stop_at_a;
  logic running, next_running;

  // Source select.
  // Encoding SRC_OSC40 picks the 40 MHz tick; each encoding indexes its tick lane.
  assign tick = src_tick_i[count_source_select_i];
  assign match_a = (counter == gr[CH_A]);
  assign stop_at_a = two_phase_pwm_mode_i & compare_stop_select_i;

  // Capture front end: pin sample, optional three-sample filter, edge select.
  for (genvar j = 0; j < NCH; j++) begin : g_cap
    logic pin_s, next_pin_s, lvl_q, next_lvl_q, filt_lvl, next_filt_lvl, lvl, hit;
    logic [FILT_TAPS-1:0] sh, next_sh;
    assign lvl = filter_enable_i[j] ? filt_lvl : pin_s;
    always_comb begin
      next_pin_s = channel_io_pin_i[j];
      next_lvl_q = lvl;
      next_sh = sh;
      next_filt_lvl = filt_lvl;
      if (filter_tick_i) begin
        next_sh = {sh[FILT_TAPS-2:0], pin_s};
        // A level passes only once every tap agrees, which rejects short glitches.
        if (&next_sh) begin
          next_filt_lvl = 1'b1;
        end else if (~|next_sh) begin
          next_filt_lvl = 1'b0;
        end
      end
    end
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        pin_s <= 1'b0;
        lvl_q <= 1'b0;
        sh <= '0;
        filt_lvl <= 1'b0;
      end else if (ce_i) begin
        pin_s <= next_pin_s;
        lvl_q <= next_lvl_q;
        sh <= next_sh;
        filt_lvl <= next_filt_lvl;
      end
    end
    // Edge select.
    // Bits 00 rising, 01 falling, 1x both edges.
    always_comb begin
      case ({edge_select_high_i[j], edge_select_low_i[j]})
        EDGE_RISE: hit = lvl & ~lvl_q;
        EDGE_FALL: hit = ~lvl & lvl_q;
        default: hit = lvl ^ lvl_q;
      endcase
    end
    // Each lane drives its own bit, so no two processes share one variable.
    assign edge_hit[j] = hit;
  end

  always_comb begin
    next_st = st;
    next_counter = counter;
    next_flags = flags;
    next_gr = gr;
    next_cnt_wr_q = cnt_wr_i;
    next_cnt_wdata_q = cnt_wdata_i;
    next_flag_wr_q = flag_wr_i;
    next_flag_wdata_q = flag_wdata_i;
    case (st)
      CNT_IDLE: begin
        if (count_start_bit_i) begin
          next_st = CNT_RUN;
        end
      end
      CNT_RUN: begin
        if (!count_start_bit_i) begin
          next_st = CNT_IDLE;
        end else if (tick && match_a && stop_at_a) begin
          next_st = CNT_HALT;
        end
      end
      CNT_HALT: begin
        if (!count_start_bit_i) begin
          next_st = CNT_IDLE;
        end
      end
      default: next_st = CNT_IDLE;
    endcase
    // The running output is registered so that it leaves the block from a flop.
    next_running = (next_st == CNT_RUN);
    // Delayed counter write.
    // The write sits one cycle in a holding stage, so a back-to-back read sees the old count.
    if (cnt_wr_q) begin
      next_counter = cnt_wdata_q;
    end
    if (st == CNT_RUN && count_start_bit_i && tick) begin
      if (match_a && compare_clear_enable_i) begin
        next_counter = '0;
      end else if (!(match_a && stop_at_a) && !cnt_wr_q) begin
        next_counter = counter + 16'h0001;
      end
    end
    if (flag_wr_q) begin
      next_flags = flag_wdata_q;
    end
    for (int j = 0; j < NCH; j++) begin
      if (gr_wr_i[j]) begin
        next_gr[j] = gr_wdata_i;
      end
      if (capture_mode_i[j]) begin
        if (edge_hit[j]) begin
          // Capture and flag.
          // Hardware set wins over a same-cycle flag write; capture works while stopped.
          next_gr[j] = counter;
          next_flags[j] = 1'b1;
        end
      end else if (st == CNT_RUN && tick && counter == gr[j]) begin
        next_flags[j] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= CNT_IDLE;
      running <= 1'b0;
      counter <= CNT_RST;
      flags <= FLAG_RST;
      gr <= {NCH{GR_RST}};
      cnt_wr_q <= 1'b0;
      cnt_wdata_q <= CNT_RST;
      flag_wr_q <= 1'b0;
      flag_wdata_q <= FLAG_RST;
    end else if (ce_i) begin
      st <= next_st;
      running <= next_running;
      counter <= next_counter;
      flags <= next_flags;
      gr <= next_gr;
      cnt_wr_q <= next_cnt_wr_q;
      cnt_wdata_q <= next_cnt_wdata_q;
      flag_wr_q <= next_flag_wr_q;
      flag_wdata_q <= next_flag_wdata_q;
    end
  end

  assign counter_value_o = counter;
  assign timer_flag_status_o = flags;
  assign channel_general_reg_o = gr;
  assign count_running_o = running;

  clear_match_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && st == CNT_RUN && count_start_bit_i && tick && match_a && compare_clear_enable_i)
    |=> (counter_value_o == 16'h0000))
    else $error("Counter did not clear on register A match.");

  clear_wins_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cnt_wr_q && cnt_wdata_q != 16'h0000 && st == CNT_RUN && count_start_bit_i && tick
     && match_a && compare_clear_enable_i) |=> (counter_value_o == 16'h0000))
    else $error("Counter write beat the match clear.");

  cnt_write_lat_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && cnt_wr_i && !cnt_wr_q && st == CNT_IDLE && !count_start_bit_i)
    ##1 (ce_i && st == CNT_IDLE && !count_start_bit_i)
    |-> (counter_value_o == $past(counter_value_o)) ##1 (counter_value_o == $past(cnt_wdata_i, 2)))
    else $error("Counter write did not land one cycle late.");

  flag_write_lat_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && flag_wr_i) ##1 ce_i
    |=> ((timer_flag_status_o & $past(flag_wdata_i, 2)) == $past(flag_wdata_i, 2)))
    else $error("Written flags did not appear after the delay.");

  capture_copy_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && capture_mode_i[0] && edge_hit[0])
    |=> (channel_general_reg_o[0] == $past(counter_value_o)))
    else $error("Capture did not copy the counter.");

  capture_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && capture_mode_i[1] && edge_hit[1]) |=> timer_flag_status_o[1])
    else $error("Capture edge did not set the channel flag.");

  pwm_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && st == CNT_RUN && count_start_bit_i && tick && match_a && stop_at_a)
    |=> (st == CNT_HALT && !count_running_o))
    else $error("Two-phase PWM did not halt at register A match.");

  halt_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && st == CNT_HALT && !cnt_wr_q) |=> $stable(counter_value_o))
    else $error("Counter moved while halted.");

  count_inc_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && st == CNT_RUN && count_start_bit_i && tick && !cnt_wr_q && !match_a)
    |=> (counter_value_o == $past(counter_value_o) + 16'h0001))
    else $error("Counter did not advance on a tick.");

  idle_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ce_i && st == CNT_IDLE && !cnt_wr_q) |=> $stable(counter_value_o))
    else $error("Counter moved while stopped.");
endmodule
`default_nettype wire

// ===== dv/cct_pin_model.sv
// Purpose: Far-side model driving the capture pins and the filter sampling tick.
// Assumes: Requests arrive by non-blocking assignment at the rising edge.
// Notes: Pulses are stretched to the legal minimum, so no scenario breaks it.
`timescale 1ns/1ps
`default_nettype none
module cct_pin_model (
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic [1:0] ch_i,
  input wire logic filt_i,
  output logic [3:0] pin_o,
  output logic filter_tick_o
);
  logic [7:0] left = 8'h00;
  initial pin_o = 4'h0;
  initial filter_tick_o = 1'b0;
  always @(posedge core_clk_i) begin
    filter_tick_o <= ~filter_tick_o;
    if (go_i) begin
      pin_o[ch_i] <= 1'b1;
      left <= filt_i ? 8'h0D : 8'h03;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      pin_o <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== dv/capture_compare_timer_test.sv
// Purpose: Self-checking bench for the capture/compare timer.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Outputs are sampled 1 ns after an edge, once its updates have landed.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_timer_test;
  import cct_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0, compare_clear_enable = 1'b0, pwm = 1'b0, stp = 1'b0;
  logic cwr = 1'b0, fwr = 1'b0, go = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] tk = 8'h00;
  logic [15:0] cwd = 16'h0000, gd = 16'h0000;
  logic [3:0] fwd = 4'h0, gw = 4'h0, cap = 4'h0, esl = 4'h0, esh = 4'h0, fen = 4'h0, pins, flg;
  logic [1:0] pch = 2'h0;
  logic ftick, run;
  logic [15:0] cnt;
  logic [3:0][15:0] gr;
  int bad_count = 0, check_count = 0, n;
  cct_timer uut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .count_start_bit_i(start),
    .compare_clear_enable_i(compare_clear_enable), .count_source_select_i(sel), .src_tick_i(tk),
    .two_phase_pwm_mode_i(pwm), .compare_stop_select_i(stp), .cnt_wr_i(cwr), .cnt_wdata_i(cwd),
    .flag_wr_i(fwr), .flag_wdata_i(fwd), .gr_wr_i(gw), .gr_wdata_i(gd), .capture_mode_i(cap),
    .edge_select_low_i(esl), .edge_select_high_i(esh), .filter_enable_i(fen),
    .filter_tick_i(ftick), .channel_io_pin_i(pins), .counter_value_o(cnt),
    .timer_flag_status_o(flg), .channel_general_reg_o(gr), .count_running_o(run));
  cct_pin_model model (.core_clk_i(clk), .go_i(go), .ch_i(pch), .filt_i(fen[pch]),
    .pin_o(pins), .filter_tick_o(ftick));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input logic [7:0] lanes, input int k);
    @(posedge clk) tk <= lanes;
    repeat (k) @(posedge clk);
    tk <= 8'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wr(input bit f, input logic [15:0] d, input logic [15:0] old);
    @(posedge clk) begin
      cwr <= !f;
      fwr <= f;
      cwd <= d;
      fwd <= d[3:0];
    end
    @(posedge clk) begin
      cwr <= 1'b0;
      fwr <= 1'b0;
    end
    #1 chk(f ? {12'h000, flg} : cnt, old);
    @(posedge clk) #1 chk(f ? {12'h000, flg} : cnt, d);
  endtask
  task automatic t_reset;
    chk(cnt, CNT_RST);
    chk({12'h000, flg}, 16'h0000);
    for (int j = 0; j < 4; j++) chk(gr[j], GR_RST);
    chk({15'h0000, run}, 16'h0000);
    $display("test reset finished");
  endtask
  task automatic t_count;
    @(posedge clk) sel <= SRC_OSC40;
    @(posedge clk) start <= 1'b1;
    tick(8'hBF, 5);
    tick(8'h40, 7);
    chk(cnt, 16'h0007);
    chk({15'h0000, run}, 16'h0001);
    // Clock enable low freezes the count even with ticks arriving.
    @(posedge clk) ce <= 1'b0;
    tick(8'h40, 3);
    chk(cnt, 16'h0007);
    chk({15'h0000, run}, 16'h0001);
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) start <= 1'b0;
    tick(8'h40, 3);
    chk(cnt, 16'h0007);
    wr(1'b0, 16'h0000, 16'h0007);
    $display("test count finished");
  endtask
  // Stop before switching.
  // The lanes given in keep tick for k cycles after the switch, then go quiet.
  task automatic move_src(input logic [2:0] to, input logic [7:0] keep, input int k, input logic [15:0] c);
    @(posedge clk) start <= 1'b0;
    @(posedge clk) sel <= to;
    tick(keep, k);
    chk(cnt, c);
    @(posedge clk) start <= 1'b1;
  endtask
  task automatic t_source;
    // Fast lane source.
    // The fast lane ticks on every cycle that tick drives it, so it is then never slower than the core clock.
    @(posedge clk) sel <= SRC_FASTFREE;
    @(posedge clk) start <= 1'b1;
    tick(8'h80, 4);
    chk(cnt, 16'h0004);
    move_src(SRC_OSC40, 8'h80, 2, 16'h0004);
    tick(8'h40, 3);
    chk(cnt, 16'h0007);
    move_src(3'h0, 8'h40, 2, 16'h0007);
    tick(8'h01, 2);
    chk(cnt, 16'h0009);
    move_src(SRC_FASTFREE, 8'h00, 1, 16'h0009);
    tick(8'h80, 1);
    chk(cnt, 16'h000A);
    move_src(3'h1, 8'hC0, 1, 16'h000A);
    tick(8'h02, 5);
    chk(cnt, 16'h000F);
    @(posedge clk) start <= 1'b0;
    wr(1'b0, 16'h0000, 16'h000F);
    // Back to the 40 MHz lane while stopped.
    @(posedge clk) sel <= SRC_OSC40;
    $display("test source finished");
  endtask
  task automatic t_clear;
    @(posedge clk) begin
      gw <= 4'h1;
      gd <= 16'h0003;
      compare_clear_enable <= 1'b1;
      start <= 1'b1;
    end
    @(posedge clk) gw <= 4'h0;
    tick(8'h40, 6);
    chk(cnt, 16'h0002);
    chk({15'h0000, flg[0]}, 16'h0001);
    // Write meets clear.
    // The held write lands on the very tick that matches register A, and the clear wins.
    @(posedge clk) begin
      cwr <= 1'b1;
      cwd <= 16'h00AA;
      tk <= 8'h40;
    end
    @(posedge clk) cwr <= 1'b0;
    @(posedge clk) tk <= 8'h00;
    #1 chk(cnt, 16'h0000);
    @(posedge clk) #1 chk(cnt, 16'h0000);
    @(posedge clk) begin
      start <= 1'b0;
      compare_clear_enable <= 1'b0;
    end
    wr(1'b0, 16'h0001, 16'h0000);
    // Mode set well before any match.
    @(posedge clk) begin
      pwm <= 1'b1;
      stp <= 1'b1;
      start <= 1'b1;
    end
    tick(8'h40, 6);
    chk(cnt, 16'h0003);
    chk({15'h0000, run}, 16'h0000);
    @(posedge clk) start <= 1'b0;
    wr(1'b1, 16'h000A, 16'h0001);
    wr(1'b1, 16'h0000, 16'h000A);
    $display("test clear and halt finished");
  endtask
  task automatic t_capture;
    wr(1'b0, 16'h1234, 16'h0003);
    @(posedge clk) begin
      cap <= 4'hF;
      esl <= 4'h4;
      esh <= 4'h8;
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge clk) begin
        fen <= (j == 0) ? 4'h1 : 4'h0;
        go <= 1'b1;
        pch <= 2'(j);
      end
      @(posedge clk) go <= 1'b0;
      n = 0;
      while (flg[j] !== 1'b1 && n < 30) @(posedge clk) #1 n++;
      chk(gr[j], 16'h1234);
      if (j > 0) chk(16'(n), (j == 2) ? 16'h0005 : 16'h0002);
      repeat (12) @(posedge clk);
    end
    $display("test capture finished");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    t_reset;
    t_count;
    t_source;
    t_clear;
    t_capture;
    wrap_up;
  end
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
